// File: rtl/tmqa_consts.svh
// Behaviour
// - take up to three messages a cycle; stage passes at most two a cycle onward
// - messages leave in arrival order through stage and main queue
// - more than three contenders: keep the three highest, drop the rest
// - overrun: stop, discard while draining to empty, then queue overrun error
// - stall mode: stall issue at threshold, release one threshold level lower
// - suppress mode: block chosen types at threshold until next lower level
// - overrun during suppression falls back to the overrun behaviour
// - older instruction outranks newer; fixed order of message kinds per instruction
// - cycle after a reported drop: error plus at most two other messages
// - simultaneous watchpoint hits merge into one watchpoint message
// - class order: error, watchpoint, class two group, rfm, status, pcm, dtm, periodic
// - error and watchpoint messages always win arbitration
// - pid ownership message dropped silently when pid correlation is on
// - lost data acquisition message raises an error message
// - lost sw ownership raises error unless beaten by pid correlation
// - lost pcm, rfm or btm raise error; any lost program trace forces sync
// - lost pid correlation reports both ownership and program trace loss
// - lost data trace is silent and forces the next data trace into sync
// - debug or power mode change emits status message with status top byte
// - error messages only with debug enabled; type 1 contention, 0 overrun
`ifndef TMQA_CONSTS_SVH
`define TMQA_CONSTS_SVH
`define TMQA_LANES 3
`define TMQA_DRAIN 2
`define TMQA_STAGE 4
`define TMQA_FIFO_DEPTH 8
`define TMQA_NCAND 15
`define TMQA_DATA_W 32
`define TMQA_ERR_PTM_BIT 2
`define TMQA_ERR_OTM_BIT 3
`define TMQA_ERR_DQ_BIT 4
`define TMQA_ERRTYPE_CONT 1'b1
`define TMQA_ERRTYPE_OVR 1'b0
`define TMQA_DS_LEN 18
`define TMQA_ERR_LEN 20
`endif

// File: rtl/tmqa_pkg.sv
package tmqa_pkg;
  typedef enum logic [3:0] {
    TMQA_ERR = 4'h0, TMQA_WPM = 4'h1, TMQA_DQM = 4'h2, TMQA_PCMPID = 4'h3,
    TMQA_OTMSW = 4'h4, TMQA_BTM = 4'h5, TMQA_RFM = 4'h6, TMQA_DSM = 4'h7,
    TMQA_PCM = 4'h8, TMQA_DTM = 4'h9, TMQA_OTMPER = 4'ha
  } tmqa_kind_t;
  typedef enum logic [1:0] {
    TMQA_POL_OVERRUN = 2'h0, TMQA_POL_STALL = 2'h1, TMQA_POL_SUPPRESS = 2'h2
  } tmqa_policy_t;
  typedef struct packed {
    logic valid;
    logic [31:0] data;
  } tmqa_req_t;
  typedef struct packed {
    tmqa_req_t i0_wp, i0_dq, i0_pcm_pid, i0_otm, i0_btm, i0_dtm;
    tmqa_req_t i1_wp, i1_dq, i1_otm, i1_btm, i1_dtm;
    tmqa_req_t evt_wp, resource_full_msg, pcm, otm_per;
  } tmqa_src_t;
  typedef struct packed {
    tmqa_kind_t kind;
    logic err_type;
    logic sync;
    logic [31:0] data;
  } tmqa_msg_t;
endpackage : tmqa_pkg

// File: rtl/tmqa.sv
`timescale 1ns/100ps
`include "tmqa_consts.svh"

// main queue: two write lanes, one read port
module tmqa_fifo #(
  parameter int W = 38,
  parameter int DEPTH = `TMQA_FIFO_DEPTH
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // fill side, lane 1 only valid with lane 0
  input wire logic [1:0] i_in_valid,
  input wire logic [1:0][W-1:0] i_in_data,
  output logic [1:0] o_in_ready,
  // drain side
  output logic o_out_valid,
  output logic [W-1:0] o_out_data,
  input wire logic i_out_ready,
  output logic [$clog2(DEPTH+1)-1:0] o_count
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [CW-1:0] cnt;
  } fst_t;
  fst_t st;
  fst_t next_st;
  logic pop;
  logic [1:0] push;

  assign o_in_ready[0] = st.cnt < CW'(DEPTH);
  assign o_in_ready[1] = st.cnt < CW'(DEPTH - 1);
  assign o_out_valid = st.cnt != '0;
  assign o_out_data = st.mem[st.rd];
  assign o_count = st.cnt;

  always_comb begin
    next_st = st;
    pop = o_out_valid && i_out_ready;
    push[0] = i_in_valid[0] && o_in_ready[0];
    push[1] = push[0] && i_in_valid[1] && o_in_ready[1];
    if (push[0]) begin
      next_st.mem[st.wr] = i_in_data[0];
    end
    if (push[1]) begin
      next_st.mem[AW'((st.wr + 1) % DEPTH)] = i_in_data[1];
    end
    next_st.wr = AW'((st.wr + push[0] + push[1]) % DEPTH);
    if (pop) begin
      next_st.rd = AW'((st.rd + 1) % DEPTH);
    end
    next_st.cnt = CW'(st.cnt + push[0] + push[1] - pop);
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule : tmqa_fifo

module tmqa_top #(
  parameter int DEPTH = `TMQA_FIFO_DEPTH
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // trace sources
  input tmqa_pkg::tmqa_src_t i_src,
  // debug status sources
  input wire logic i_debug_mode,
  input wire logic [1:0] i_low_power,
  input wire logic [7:0] i_dev_status_top,
  // configuration
  input wire logic i_debug_en,
  input wire logic i_trace_en,
  input wire logic i_prog_trace_en,
  input wire logic i_pid_corr_unmasked,
  input tmqa_pkg::tmqa_policy_t i_overrun_policy_control,
  input wire logic [1:0] i_threshold_level,
  input wire logic [10:0] i_suppress_mask,
  // status
  output logic o_issue_stall,
  output logic o_suppress_active,
  output logic o_overrun_active,
  output logic [$clog2(DEPTH+1)-1:0] o_fill,
  // drain to output port
  output logic o_msg_valid,
  output tmqa_pkg::tmqa_msg_t o_msg,
  input wire logic i_msg_ready
);
  localparam int NC = `TMQA_NCAND;
  localparam int MW = $bits(tmqa_pkg::tmqa_msg_t);
  localparam int CW = $clog2(DEPTH+1);

  typedef struct packed {
    logic [`TMQA_STAGE-1:0][MW-1:0] stage;
    logic [2:0] stage_cnt;
    logic ovr;
    logic [10:0] ovr_mask;
    logic err_v;
    logic [7:0] err_code;
    logic sync_btm;
    logic sync_dtm;
    logic stall;
    logic supp;
    logic prev_dbg;
    logic [1:0] prev_lp;
  } tmqa_state_t;

  tmqa_state_t st;
  tmqa_state_t next_st;

  logic [NC-1:0] cand_v;
  tmqa_pkg::tmqa_msg_t [NC-1:0] cand_m;
  logic [NC-1:0] win;
  logic [NC-1:0] lost;
  logic [1:0] lane_v;
  logic [1:0][MW-1:0] lane_d;
  logic [1:0] lane_rdy;
  logic [CW-1:0] fcnt;
  logic fifo_empty;
  logic [2:0] n_win;
  logic [2:0] n_pop;
  logic ds_evt;
  logic wp_any;
  logic otm_blocked;
  logic [7:0] new_code;
  logic fits_now;
  logic [2:0] base_now;

  function automatic tmqa_pkg::tmqa_msg_t mk(input tmqa_pkg::tmqa_kind_t k,
                                             input logic [31:0] d, input logic s);
    tmqa_pkg::tmqa_msg_t m;
    m.kind = k;
    m.err_type = 1'b0;
    m.sync = s;
    m.data = d;
    return m;
  endfunction : mk

  // level in quarter steps of the main queue
  function automatic logic [CW-1:0] quarter(input logic [1:0] lvl);
    return CW'((int'(lvl) * DEPTH) / 4);
  endfunction : quarter

  function automatic logic fill_hold(input logic act, input logic [1:0] lvl,
                                     input logic [CW-1:0] cnt);
    if (lvl == 2'h0) begin
      return 1'b0;
    end else if (act) begin
      return cnt > quarter(lvl - 2'h1);
    end
    return cnt >= quarter(lvl);
  endfunction : fill_hold

  assign ds_evt = i_trace_en && (i_debug_mode != st.prev_dbg || i_low_power != st.prev_lp);
  assign wp_any = i_src.i0_wp.valid || i_src.i1_wp.valid || i_src.evt_wp.valid;
  // the correlation message already carries the pid value
  assign otm_blocked = i_prog_trace_en && i_pid_corr_unmasked;

  // candidates in fixed priority order, index 0 highest
  always_comb begin
    cand_v = '0;
    cand_m[0] = mk(tmqa_pkg::TMQA_ERR, {24'h000000, st.err_code}, 1'b0);
    cand_m[0].err_type = `TMQA_ERRTYPE_CONT;
    cand_v[0] = st.err_v;
    cand_m[1] = mk(tmqa_pkg::TMQA_WPM,
                   i_src.i0_wp.data | i_src.i1_wp.data | i_src.evt_wp.data, 1'b0);
    cand_v[1] = wp_any;
    cand_m[2] = mk(tmqa_pkg::TMQA_DQM, i_src.i0_dq.data, 1'b0);
    cand_v[2] = i_src.i0_dq.valid;
    cand_m[3] = mk(tmqa_pkg::TMQA_PCMPID, i_src.i0_pcm_pid.data, 1'b0);
    cand_v[3] = i_src.i0_pcm_pid.valid;
    cand_m[4] = mk(tmqa_pkg::TMQA_OTMSW, i_src.i0_otm.data, 1'b0);
    cand_v[4] = i_src.i0_otm.valid && !otm_blocked;
    cand_m[5] = mk(tmqa_pkg::TMQA_BTM, i_src.i0_btm.data, st.sync_btm);
    cand_v[5] = i_src.i0_btm.valid;
    cand_m[6] = mk(tmqa_pkg::TMQA_DQM, i_src.i1_dq.data, 1'b0);
    cand_v[6] = i_src.i1_dq.valid;
    cand_m[7] = mk(tmqa_pkg::TMQA_OTMSW, i_src.i1_otm.data, 1'b0);
    cand_v[7] = i_src.i1_otm.valid && !otm_blocked;
    cand_m[8] = mk(tmqa_pkg::TMQA_BTM, i_src.i1_btm.data, st.sync_btm && !i_src.i0_btm.valid);
    cand_v[8] = i_src.i1_btm.valid;
    cand_m[9] = mk(tmqa_pkg::TMQA_RFM, i_src.resource_full_msg.data, 1'b0);
    cand_v[9] = i_src.resource_full_msg.valid;
    cand_m[10] = mk(tmqa_pkg::TMQA_DSM, {24'h000000, i_dev_status_top}, 1'b0);
    cand_v[10] = ds_evt;
    cand_m[11] = mk(tmqa_pkg::TMQA_PCM, i_src.pcm.data, 1'b0);
    cand_v[11] = i_src.pcm.valid;
    cand_m[12] = mk(tmqa_pkg::TMQA_DTM, i_src.i0_dtm.data, st.sync_dtm);
    cand_v[12] = i_src.i0_dtm.valid;
    cand_m[13] = mk(tmqa_pkg::TMQA_DTM, i_src.i1_dtm.data, st.sync_dtm && !i_src.i0_dtm.valid);
    cand_v[13] = i_src.i1_dtm.valid;
    cand_m[14] = mk(tmqa_pkg::TMQA_OTMPER, i_src.otm_per.data, 1'b0);
    cand_v[14] = i_src.otm_per.valid;
    // suppression blocks chosen kinds, never errors or watchpoints
    for (int i = 2; i < NC; i++) begin
      if (st.supp && i_suppress_mask[cand_m[i].kind]) begin
        cand_v[i] = 1'b0;
      end
    end
  end

  // take the first three in priority order, losers feed the drop responses
  always_comb begin
    win = '0;
    lost = '0;
    n_win = 3'h0;
    for (int i = 0; i < NC; i++) begin
      if (cand_v[i] && n_win < 3'(`TMQA_LANES)) begin
        win[i] = 1'b1;
        n_win = n_win + 3'h1;
      end else if (cand_v[i]) begin
        lost[i] = 1'b1;
      end
    end
  end

  always_comb begin
    new_code = 8'h00;
    if (lost[2] || lost[6]) begin
      new_code[`TMQA_ERR_DQ_BIT] = 1'b1;
    end
    if ((lost[4] && !win[3]) || lost[7]) begin
      new_code[`TMQA_ERR_OTM_BIT] = 1'b1;
    end
    if (lost[3]) begin
      new_code[`TMQA_ERR_OTM_BIT] = 1'b1;
      new_code[`TMQA_ERR_PTM_BIT] = 1'b1;
    end
    if (lost[5] || lost[8] || lost[9] || lost[11]) begin
      new_code[`TMQA_ERR_PTM_BIT] = 1'b1;
    end
  end

  // stage pops at most two into the main queue each cycle
  always_comb begin
    lane_v[0] = st.stage_cnt != 3'h0;
    lane_v[1] = st.stage_cnt > 3'h1;
    lane_d[0] = st.stage[0];
    lane_d[1] = st.stage[1];
    n_pop = 3'h0;
    if (lane_v[0] && lane_rdy[0]) begin
      n_pop = (lane_v[1] && lane_rdy[1]) ? 3'(`TMQA_DRAIN) : 3'h1;
    end
  end

  always_comb begin
    logic [2:0] base;
    logic [2:0] k;
    logic fits;
    tmqa_pkg::tmqa_msg_t om;
    base = 3'h0;
    k = 3'h0;
    fits = 1'b0;
    om = mk(tmqa_pkg::TMQA_ERR, {21'h0, st.ovr_mask}, 1'b0);
    next_st = st;
    next_st.prev_dbg = i_debug_mode;
    next_st.prev_lp = i_low_power;
    // shift out what left, keeping the survivors at the front
    for (int i = 0; i < `TMQA_STAGE; i++) begin
      next_st.stage[i] = (3'(i) + n_pop < 3'(`TMQA_STAGE)) ? st.stage[3'(i) + n_pop] : '0;
    end
    base = st.stage_cnt - n_pop;
    fits = (4'(base) + 4'(n_win)) <= 4'(`TMQA_STAGE);
    next_st.stage_cnt = base;
    next_st.err_v = 1'b0;
    if (st.ovr) begin
      // discard everything until the whole queue has emptied
      for (int i = 0; i < NC; i++) begin
        if (cand_v[i]) begin
          next_st.ovr_mask[cand_m[i].kind] = 1'b1;
        end
      end
      if (st.stage_cnt == 3'h0 && fifo_empty) begin
        next_st.ovr = 1'b0;
        next_st.ovr_mask = '0;
        if (i_debug_en) begin
          om.err_type = `TMQA_ERRTYPE_OVR;
          next_st.stage[0] = om;
          next_st.stage_cnt = 3'h1;
        end
      end
    end else if (!fits && n_win != 3'h0) begin
      // same fallback whatever the policy, so skid in stall mode is safe too
      next_st.ovr = 1'b1;
      for (int i = 0; i < NC; i++) begin
        if (cand_v[i]) begin
          next_st.ovr_mask[cand_m[i].kind] = 1'b1;
        end
      end
    end else begin
      for (int i = 0; i < NC; i++) begin
        if (win[i]) begin
          next_st.stage[base + k] = cand_m[i];
          k = k + 3'h1;
        end
      end
      next_st.stage_cnt = base + k;
      next_st.err_v = i_debug_en && new_code != 8'h00;
      next_st.err_code = new_code;
      // a pending upgrade is kept until a message of that kind gets through
      if (win[5] || win[8]) begin
        next_st.sync_btm = 1'b0;
      end
      if (win[12] || win[13]) begin
        next_st.sync_dtm = 1'b0;
      end
      if (|{lost[3], lost[5], lost[8], lost[9], lost[10], lost[11]}) begin
        next_st.sync_btm = 1'b1;
      end
      if (lost[12] || lost[13]) begin
        next_st.sync_dtm = 1'b1;
      end
    end
    next_st.stall = (i_overrun_policy_control == tmqa_pkg::TMQA_POL_STALL) &&
                    fill_hold(st.stall, i_threshold_level, fcnt);
    next_st.supp = (i_overrun_policy_control == tmqa_pkg::TMQA_POL_SUPPRESS) &&
                   fill_hold(st.supp, i_threshold_level, fcnt);
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  tmqa_fifo #(
    .W(MW),
    .DEPTH(DEPTH)
  ) u_fifo (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_in_valid(lane_v),
    .i_in_data(lane_d),
    .o_in_ready(lane_rdy),
    .o_out_valid(o_msg_valid),
    .o_out_data(o_msg),
    .i_out_ready(i_msg_ready),
    .o_count(fcnt)
  );

  assign fifo_empty = fcnt == '0;
  assign o_fill = fcnt;
  assign o_issue_stall = st.stall;
  assign o_suppress_active = st.supp;
  assign o_overrun_active = st.ovr;

  a_stage_drain: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    st.stage_cnt >= 3'h2 && lane_rdy[1] |=> st.stage_cnt <= $past(st.stage_cnt) + 3'h1)
    else $error("stage drained fewer than two");
  a_three_max: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !st.ovr && $countones(cand_v) > 3 && fits_now |=> st.stage_cnt == $past(base_now) + 3'h3)
    else $error("three highest not all stored");
  a_wp_kept: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    wp_any |-> win[1])
    else $error("watchpoint lost arbitration");
  a_err_kept: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    st.err_v |-> win[0] && !lost[0])
    else $error("error message lost arbitration");
  a_dq_loss_err: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_debug_en && !st.ovr && fits_now && (lost[2] || lost[6]) |=> st.err_v && st.err_code[4])
    else $error("lost data acquisition not reported");
  a_dtm_sync: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !st.ovr && fits_now && (lost[12] || lost[13]) |=> st.sync_dtm)
    else $error("lost data trace not upgraded");
  a_pid_loss: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_debug_en && !st.ovr && fits_now && lost[3] |=> st.err_code[3:2] == 2'h3)
    else $error("lost pid correlation code wrong");
  a_otm_block: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    otm_blocked |-> !cand_v[4] && !cand_v[7])
    else $error("pid ownership message not blocked");
  a_stall_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_overrun_policy_control == tmqa_pkg::TMQA_POL_STALL && i_threshold_level == 2'h1 &&
    st.stall && fcnt != '0 ##1 i_overrun_policy_control == tmqa_pkg::TMQA_POL_STALL &&
    i_threshold_level == 2'h1 |-> st.stall)
    else $error("stall released before empty");
  a_ovr_drain: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    st.ovr && st.stage_cnt == 3'h0 && fifo_empty && i_debug_en |=>
    !st.ovr && st.stage_cnt == 3'h1 && st.stage[0][MW-1 -: 5] == 5'h00)
    else $error("overrun error not queued after drain");

  assign base_now = st.stage_cnt - n_pop;
  assign fits_now = (4'(base_now) + 4'(n_win)) <= 4'(`TMQA_STAGE);
endmodule : tmqa_top

// File: verif/tmqa_sink.sv
`timescale 1ns/100ps

// output port model: takes one message per edge while not held off
module tmqa_sink (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // pacing from the bench, high stalls the port
  input wire logic i_hold,
  // message stream from the queue
  input wire logic i_msg_valid,
  input tmqa_pkg::tmqa_msg_t i_msg,
  output logic o_msg_ready
);
  tmqa_pkg::tmqa_msg_t got[$];

  assign o_msg_ready = !i_hold;

  always @(posedge i_sys_clk) begin
    if (!i_rst && i_msg_valid && o_msg_ready) begin
      got.push_back(i_msg);
    end
  end
endmodule : tmqa_sink

// File: verif/tb_top.sv
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb_top;
  localparam logic [37:0] M_ALL = 38'h3f_ffff_ffff;
  localparam logic [37:0] M_NOSYNC = 38'h3e_ffff_ffff;
  localparam logic [37:0] M_ERR = 38'h3e_0000_00ff;
  localparam logic [37:0] M_OVR = 38'h3e_0000_07ff;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  tmqa_pkg::tmqa_src_t i_src = '0;
  logic i_debug_mode = 1'b0;
  logic [1:0] i_low_power = 2'h0;
  logic [7:0] i_dev_status_top = 8'h00;
  logic i_prog_trace_en = 1'b0;
  logic i_pid_corr_unmasked = 1'b0;
  logic i_debug_en = 1'b1;
  logic i_trace_en = 1'b1;
  tmqa_pkg::tmqa_policy_t i_overrun_policy_control = tmqa_pkg::TMQA_POL_OVERRUN;
  logic [1:0] i_threshold_level = 2'h0;
  logic [10:0] i_suppress_mask = 11'h000;
  logic hold = 1'b0;
  logic o_issue_stall;
  logic o_suppress_active;
  logic o_overrun_active;
  logic [3:0] o_fill;
  logic o_msg_valid;
  tmqa_pkg::tmqa_msg_t o_msg;
  logic i_msg_ready;
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [37:0] exp_q[$];
  logic [37:0] msk_q[$];

  always #12.5 i_sys_clk = ~i_sys_clk;

  tmqa_top #(.DEPTH(8)) uut (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_src(i_src),
    .i_debug_mode(i_debug_mode), .i_low_power(i_low_power),
    .i_dev_status_top(i_dev_status_top), .i_debug_en(i_debug_en), .i_trace_en(i_trace_en),
    .i_prog_trace_en(i_prog_trace_en), .i_pid_corr_unmasked(i_pid_corr_unmasked),
    .i_overrun_policy_control(i_overrun_policy_control),
    .i_threshold_level(i_threshold_level), .i_suppress_mask(i_suppress_mask),
    .o_issue_stall(o_issue_stall), .o_suppress_active(o_suppress_active),
    .o_overrun_active(o_overrun_active), .o_fill(o_fill),
    .o_msg_valid(o_msg_valid), .o_msg(o_msg), .i_msg_ready(i_msg_ready)
  );

  tmqa_sink u_sink (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_hold(hold),
    .i_msg_valid(o_msg_valid), .i_msg(o_msg), .o_msg_ready(i_msg_ready)
  );

  function automatic tmqa_pkg::tmqa_req_t rq(input logic [31:0] d);
    return '{1'b1, d};
  endfunction : rq

  task automatic pulse(input tmqa_pkg::tmqa_src_t s);
    @(posedge i_sys_clk);
    i_src <= s;
  endtask : pulse

  task automatic expect_msg(input tmqa_pkg::tmqa_kind_t k, input logic et, input logic sy,
                            input logic [31:0] d, input logic [37:0] m);
    exp_q.push_back({k, et, sy, d});
    msk_q.push_back(m);
  endtask : expect_msg

  // waits for the expected count, then lets stray extra messages arrive too
  task automatic check_all();
    int n;
    n = 0;
    while (u_sink.got.size() < exp_q.size() && n < 300) begin
      @(posedge i_sys_clk);
      n++;
    end
    repeat (10) @(posedge i_sys_clk);
    `CHK(u_sink.got.size(), exp_q.size())
    foreach (exp_q[i]) begin
      if (i < u_sink.got.size()) `CHK(u_sink.got[i] & msk_q[i], exp_q[i] & msk_q[i])
    end
    u_sink.got.delete();
    exp_q.delete();
    msk_q.delete();
  endtask : check_all

  task automatic tally_and_finish();
    $display("mismatches %0d, comparisons %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  initial begin
    tmqa_pkg::tmqa_src_t s;
    int n;
    logic [37:0] ov;
    repeat (12) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    // four contenders: lowest one lost without error
    s = '0; s.i0_dq = rq(32'h11); s.i0_btm = rq(32'h12);
    s.i1_btm = rq(32'h13); s.i0_dtm = rq(32'h14);
    pulse(s); pulse('0);
    expect_msg(tmqa_pkg::TMQA_DQM, 1'b0, 1'b0, 32'h11, M_NOSYNC);
    expect_msg(tmqa_pkg::TMQA_BTM, 1'b0, 1'b0, 32'h12, M_NOSYNC);
    expect_msg(tmqa_pkg::TMQA_BTM, 1'b0, 1'b0, 32'h13, M_NOSYNC);
    check_all();
    s = '0; s.i0_dtm = rq(32'h15); pulse(s); pulse('0);
    expect_msg(tmqa_pkg::TMQA_DTM, 1'b0, 1'b1, 32'h15, M_ALL);
    check_all();
    // branch loss, then the error takes a lane and a pid correlation is lost
    s = '0; s.i0_dq = rq(32'h21); s.i0_btm = rq(32'h22);
    s.i1_dq = rq(32'h23); s.i1_btm = rq(32'h24); pulse(s);
    s = '0; s.i0_wp = rq(32'h25); s.i0_dq = rq(32'h26); s.i0_pcm_pid = rq(32'h27);
    pulse(s); pulse('0);
    expect_msg(tmqa_pkg::TMQA_DQM, 1'b0, 1'b0, 32'h21, M_NOSYNC);
    expect_msg(tmqa_pkg::TMQA_BTM, 1'b0, 1'b0, 32'h22, M_NOSYNC);
    expect_msg(tmqa_pkg::TMQA_DQM, 1'b0, 1'b0, 32'h23, M_NOSYNC);
    expect_msg(tmqa_pkg::TMQA_ERR, 1'b1, 1'b0, 32'h04, M_ERR);
    expect_msg(tmqa_pkg::TMQA_WPM, 1'b0, 1'b0, 32'h25, M_NOSYNC);
    expect_msg(tmqa_pkg::TMQA_DQM, 1'b0, 1'b0, 32'h26, M_NOSYNC);
    expect_msg(tmqa_pkg::TMQA_ERR, 1'b1, 1'b0, 32'h0c, M_ERR);
    check_all();
    s = '0; s.i1_btm = rq(32'h28); pulse(s); pulse('0);
    expect_msg(tmqa_pkg::TMQA_BTM, 1'b0, 1'b1, 32'h28, M_ALL);
    check_all();
    // merged watchpoints and a lost data acquisition
    s = '0; s.i0_wp = rq(32'h100); s.i1_wp = rq(32'h200); s.evt_wp = rq(32'h400);
    s.i0_dq = rq(32'h33); s.i0_btm = rq(32'h34); s.i1_dq = rq(32'h35);
    pulse(s); pulse('0);
    expect_msg(tmqa_pkg::TMQA_WPM, 1'b0, 1'b0, 32'h700, M_NOSYNC);
    expect_msg(tmqa_pkg::TMQA_DQM, 1'b0, 1'b0, 32'h33, M_NOSYNC);
    expect_msg(tmqa_pkg::TMQA_BTM, 1'b0, 1'b0, 32'h34, M_NOSYNC);
    expect_msg(tmqa_pkg::TMQA_ERR, 1'b1, 1'b0, 32'h10, M_ERR);
    check_all();
    // ownership beaten by pid correlation and periodic ownership: both silent
    s = '0; s.i0_wp = rq(32'h40); s.i0_dq = rq(32'h41); s.i0_pcm_pid = rq(32'h42);
    s.i0_otm = rq(32'h43); s.otm_per = rq(32'h48); pulse(s); pulse('0);
    expect_msg(tmqa_pkg::TMQA_WPM, 1'b0, 1'b0, 32'h40, M_NOSYNC);
    expect_msg(tmqa_pkg::TMQA_DQM, 1'b0, 1'b0, 32'h41, M_NOSYNC);
    expect_msg(tmqa_pkg::TMQA_PCMPID, 1'b0, 1'b0, 32'h42, M_NOSYNC);
    check_all();
    s = '0; s.i0_wp = rq(32'h44); s.i0_dq = rq(32'h45); s.i0_btm = rq(32'h46);
    s.i1_otm = rq(32'h47); pulse(s); pulse('0);
    expect_msg(tmqa_pkg::TMQA_WPM, 1'b0, 1'b0, 32'h44, M_NOSYNC);
    expect_msg(tmqa_pkg::TMQA_DQM, 1'b0, 1'b0, 32'h45, M_NOSYNC);
    expect_msg(tmqa_pkg::TMQA_BTM, 1'b0, 1'b0, 32'h46, M_NOSYNC);
    expect_msg(tmqa_pkg::TMQA_ERR, 1'b1, 1'b0, 32'h08, M_ERR);
    check_all();
    // pid updates covered by correlation are dropped without error
    i_prog_trace_en <= 1'b1; i_pid_corr_unmasked <= 1'b1;
    s = '0; s.i0_otm = rq(32'h50); pulse(s); pulse('0);
    check_all();
    i_prog_trace_en <= 1'b0; i_pid_corr_unmasked <= 1'b0;
    s = '0; s.i0_otm = rq(32'h51); pulse(s); pulse('0);
    expect_msg(tmqa_pkg::TMQA_OTMSW, 1'b0, 1'b0, 32'h51, M_NOSYNC);
    check_all();
    // status byte is set a cycle ahead of each mode change
    i_dev_status_top <= 8'h5a; @(posedge i_sys_clk); i_debug_mode <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    i_dev_status_top <= 8'h3c; @(posedge i_sys_clk); i_low_power <= 2'h2;
    expect_msg(tmqa_pkg::TMQA_DSM, 1'b0, 1'b0, 32'h5a, M_ERR);
    expect_msg(tmqa_pkg::TMQA_DSM, 1'b0, 1'b0, 32'h3c, M_ERR);
    check_all();
    // debug off drops the lost-dq error, trace off drops the status message
    i_debug_en <= 1'b0;
    i_trace_en <= 1'b0;
    i_debug_mode <= 1'b0;
    s = '0; s.i0_wp = rq(32'h90); s.i0_dq = rq(32'h91); s.i0_btm = rq(32'h92);
    s.i1_dq = rq(32'h93); pulse(s); pulse('0);
    expect_msg(tmqa_pkg::TMQA_WPM, 1'b0, 1'b0, 32'h90, M_NOSYNC);
    expect_msg(tmqa_pkg::TMQA_DQM, 1'b0, 1'b0, 32'h91, M_NOSYNC);
    expect_msg(tmqa_pkg::TMQA_BTM, 1'b0, 1'b0, 32'h92, M_NOSYNC);
    check_all();
    i_debug_en <= 1'b1;
    i_trace_en <= 1'b1;
    // stall at a quarter (2 words), released only at empty
    i_overrun_policy_control <= tmqa_pkg::TMQA_POL_STALL; i_threshold_level <= 2'h1;
    hold <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      s = '0; s.resource_full_msg = rq(32'h60 + k); pulse(s);
      expect_msg(tmqa_pkg::TMQA_RFM, 1'b0, 1'b0, 32'h60 + k, M_NOSYNC);
    end
    pulse('0); repeat (6) @(posedge i_sys_clk);
    `CHK(o_issue_stall, 1'b1)
    `CHK(o_fill, 4'h3)
    for (int k = 0; k < 3; k++) begin
      hold <= 1'b0; @(posedge i_sys_clk); hold <= 1'b1;
      repeat (4) @(posedge i_sys_clk);
      `CHK(o_issue_stall, 1'(k < 2))
    end
    hold <= 1'b0;
    check_all();
    // suppress data trace at half, then overrun while suppressing
    i_overrun_policy_control <= tmqa_pkg::TMQA_POL_SUPPRESS; i_threshold_level <= 2'h2;
    i_suppress_mask <= 11'h200; hold <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      s = '0; s.resource_full_msg = rq(32'h70 + k); pulse(s);
    end
    pulse('0); repeat (6) @(posedge i_sys_clk);
    `CHK(o_suppress_active, 1'b1)
    s = '0; s.i0_dtm = rq(32'h74); pulse(s);
    n = 0;
    while (!o_overrun_active && n < 20) begin
      s = '0; s.resource_full_msg = rq(32'h80 + n); pulse(s); #1;
      n++;
    end
    s = '0; s.i0_btm = rq(32'h99); pulse(s); pulse('0); #1;
    `CHK(o_overrun_active, 1'b1)
    hold <= 1'b0;
    n = 0;
    while ((o_overrun_active || o_msg_valid) && n < 200) begin
      @(posedge i_sys_clk); #1;
      n++;
    end
    repeat (10) @(posedge i_sys_clk);
    ov = {tmqa_pkg::TMQA_ERR, 1'b0, 1'b0, 32'h060};
    `CHK(u_sink.got.size() > 4, 1'b1)
    `CHK(u_sink.got[$] & M_OVR, ov & M_OVR)
    for (int i = 0; i + 1 < u_sink.got.size(); i++) `CHK(u_sink.got[i].kind, tmqa_pkg::TMQA_RFM)
    `CHK(o_suppress_active, 1'b0)
    u_sink.got.delete();
    tally_and_finish();
  end
endmodule : tb_top
